/* File: pkg/ppc_pkg.sv */
// ppc_pkg: shared constants and types of the port pin configuration block
`default_nettype none
package ppc_pkg;
	// ************************************************************
	// port arrangement
	// ************************************************************
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 8;
	localparam int PORT_SEL_W = 2;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_R = 2;
	localparam int PORT_AD = 3;
	// per-port capability, one bit per port index
	localparam logic [NUM_PORTS-1:0] PORT_HAS_INT = 4'hc;
	localparam logic [NUM_PORTS-1:0] POL_FIXED_EN = 4'hb;
	localparam logic [NUM_PORTS-1:0] POL_FIXED_VAL = 4'h3;
	// alternate function bit positions on port A
	localparam int PA_IRQ_BIT = 0;
	localparam int PA_NMI_BIT = 1;
	localparam int PA_WKUP_BIT = 3;

	// ************************************************************
	// register map (word indices, byte address = index * 4)
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam int WORD_LSB = 2;
	localparam logic [IDX_W-1:0] IDX_DATA_A = 10'h000;
	localparam logic [IDX_W-1:0] IDX_DATA_B = 10'h001;
	localparam logic [IDX_W-1:0] IDX_DATA_END = 10'h004;
	localparam logic [IDX_W-1:0] IDX_CFG_BASE = 10'h010;
	localparam logic [IDX_W-1:0] IDX_CFG_END = 10'h030;
	localparam int CFG_FIELD_W = 3;
	localparam logic [ADDR_W-1:0] ADDR_DATA_A = {IDX_DATA_A, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DATA_B = {IDX_DATA_B, 2'h0};
	// field codes inside one port's configuration group
	localparam logic [CFG_FIELD_W-1:0] FLD_DATA = 3'h0;
	localparam logic [CFG_FIELD_W-1:0] FLD_DIR = 3'h1;
	localparam logic [CFG_FIELD_W-1:0] FLD_RDR = 3'h2;
	localparam logic [CFG_FIELD_W-1:0] FLD_PULL_EN = 3'h3;
	localparam logic [CFG_FIELD_W-1:0] FLD_PULL_POL = 3'h4;
	localparam logic [CFG_FIELD_W-1:0] FLD_INT_EN = 3'h5;
	localparam logic [CFG_FIELD_W-1:0] FLD_FLAG = 3'h6;
	localparam logic [CFG_FIELD_W-1:0] FLD_PIN = 3'h7;
	localparam logic [PORT_W-1:0] REG_RST = 8'h00;

	// ************************************************************
	// types
	// ************************************************************
	typedef logic [PORT_W-1:0] ppc_byte_t;
	typedef ppc_byte_t [NUM_PORTS-1:0] ppc_bank_t;
	typedef struct packed {
		ppc_bank_t dataLatch;
		ppc_bank_t dir;
		ppc_bank_t reducedDrive;
		ppc_bank_t pullEnable;
		ppc_bank_t pullPolarity;
		ppc_bank_t pinIntEnable;
		ppc_bank_t flag;
		logic [31:0] rdData;
		logic slvErr;
	} ppc_top_st_t;
endpackage : ppc_pkg
`default_nettype wire

/* File: pkg/ppc_port_if.sv */
// ppc_port_if: configuration and results between register file and one pin bank
`timescale 1ns/1ns
`default_nettype none
interface ppc_port_if #(parameter int W = 8);
	logic [W-1:0] dir;
	logic [W-1:0] level;
	logic [W-1:0] reduced;
	logic [W-1:0] pullEn;
	logic [W-1:0] pullPol;
	logic [W-1:0] intEn;
	logic [W-1:0] lcdEn;
	logic [W-1:0] altOut;
	logic [W-1:0] altOutVal;
	logic [W-1:0] altIn;
	logic [W-1:0] syncPin;
	logic [W-1:0] edgeHit;
	modport ctl (
		output dir, level, reduced, pullEn, pullPol, intEn, lcdEn, altOut, altOutVal, altIn,
		input syncPin, edgeHit
	);
	modport bank (
		input dir, level, reduced, pullEn, pullPol, intEn, lcdEn, altOut, altOutVal, altIn,
		output syncPin, edgeHit
	);
endinterface : ppc_port_if
`default_nettype wire

/* File: core/ppc_pin_bank.sv */
// ppc_pin_bank: pad control, input synchroniser and edge detection for one port
`timescale 1ns/1ns
`default_nettype none
module ppc_pin_bank
	import ppc_pkg::*;
#(
	parameter int W = PORT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register side
	ppc_port_if.bank port,
	// pad side
	input wire logic [W-1:0] pinIn,
	output logic [W-1:0] pinOut,
	output logic [W-1:0] pinOen_n,
	output logic [W-1:0] pinReduced,
	output logic [W-1:0] pinPullUp,
	output logic [W-1:0] pinPullDown,
	output logic [W-1:0] pinInBufEn
);
	typedef struct packed {
		logic [W-1:0] sync1;
		logic [W-1:0] sync2;
		logic [W-1:0] prev;
	} ppc_bank_st_t;

	ppc_bank_st_t st;
	ppc_bank_st_t next_st;
	logic [W-1:0] outEn;
	logic [W-1:0] inMode;

	if (W < 1) begin : g_chk
		$error("ppc_pin_bank: W must be at least 1");
	end

	// ************************************************************
	// pad control per pin
	// ************************************************************
	for (genvar i = 0; i < W; i++) begin : g_pin
		// segment beats alternate output/input, which beat the direction bit
		assign outEn[i] = !port.lcdEn[i] && (port.altOut[i] || (!port.altIn[i] && port.dir[i]));
		assign inMode[i] = !port.lcdEn[i] && !outEn[i];
		assign pinOen_n[i] = !outEn[i];
		assign pinOut[i] = outEn[i] && (port.altOut[i] ? port.altOutVal[i] : port.level[i]);
		assign pinReduced[i] = outEn[i] && !port.altOut[i] && port.reduced[i];
		assign pinPullUp[i] = inMode[i] && port.pullEn[i] && !port.pullPol[i];
		assign pinPullDown[i] = inMode[i] && port.pullEn[i] && port.pullPol[i];
		assign pinInBufEn[i] = !port.lcdEn[i];
		// polarity 1 watches rising, 0 falling, in either direction
		assign port.edgeHit[i] = port.intEn[i] && (port.pullPol[i] ?
			(st.sync2[i] && !st.prev[i]) : (!st.sync2[i] && st.prev[i]));
	end

	assign port.syncPin = st.sync2;

	// ************************************************************
	// state
	// ************************************************************
	always_comb begin
		next_st = st;
		next_st.sync1 = pinIn & pinInBufEn;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_pullOffOut;
		(~pinOen_n & (pinPullUp | pinPullDown)) == '0;
	endproperty
	a_pullOffOut: assert property (p_pullOffOut) else $error("pull active on driven pin");

	property p_lcdOff;
		(port.lcdEn & (~pinOen_n | pinInBufEn)) == '0;
	endproperty
	a_lcdOff: assert property (p_lcdOff) else $error("segment pin has digital buffer on");

	property p_gpDrive;
		((port.dir & ~port.lcdEn & ~port.altOut & ~port.altIn) != '0) |->
			((port.dir & ~port.lcdEn & ~port.altOut & ~port.altIn &
			((pinOut ^ port.level) | (pinReduced ^ port.reduced) | pinOen_n)) == '0);
	endproperty
	a_gpDrive: assert property (p_gpDrive) else $error("output pin level or strength wrong");

	property p_fallEdge;
		(port.intEn & ~port.pullPol & $past(port.syncPin) & ~port.syncPin & ~port.edgeHit) == '0;
	endproperty
	a_fallEdge: assert property (p_fallEdge) else $error("falling edge not reported");

	sequence s_padSteady;
		($stable(pinIn) && $stable(pinInBufEn)) [*3];
	endsequence
	property p_syncLag;
		s_padSteady |-> (port.syncPin == (pinIn & pinInBufEn));
	endproperty
	a_syncLag: assert property (p_syncLag) else $error("pin state not seen in two cycles");
endmodule : ppc_pin_bank
`default_nettype wire

/* File: core/ppc_port_ab.sv */
// ppc_port_ab: port pin configuration with ports A and B data registers on APB
//
// Contract
// - with interrupt enabled, polarity 0 senses falling edges, 1 rising, any direction
// - input with pull enabled: polarity 0 pulls up, 1 pulls down
// - output direction always switches the pull device off; code keeps it on port A bits 0 and 1 while their interrupt input is enabled
// - output, normal drive: pin driven full strength to the output level
// - output, reduced drive set: pin driven to the level at reduced strength
// - polarity fixed at 1 on ports A and B, at 0 on the analog port
// - pin interrupt enable exists only on interrupt-capable ports
// - register reads only ever show clock-synchronous values
// - data read returns latch when direction is 1, else synchronised pin
// - general purpose output drives each latch bit onto its pin
// - an enabled segment overrides all other functions of the pin
// - port A bit 3 wakeup clock output overrides I/O, below segment
// - port A bit 1 nonmaskable interrupt input overrides I/O, below segment
// - port A bit 0 maskable interrupt input overrides I/O, below segment
// - port A data: 8 bits, index 0x0000, read/write anytime, resets to zero
// - port B data: 8 bits, index 0x0001, read/write anytime, resets to zero
// - after a direction change the read source settles within two cycles
// - enabled segment forces the pin's digital input and output buffers off
`timescale 1ns/1ns
`default_nettype none
module ppc_port_ab
	import ppc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pads, index 0 port A, 1 port B, 2 port R, 3 analog port
	input wire logic [NUM_PORTS-1:0][PORT_W-1:0] pinIn,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinOut,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinOen_n,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinReduced,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinPullUp,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinPullDown,
	output logic [NUM_PORTS-1:0][PORT_W-1:0] pinInBufEn,
	// segment driver enables for ports A and B
	input wire logic [PORT_W-1:0] lcdSegEnA,
	input wire logic [PORT_W-1:0] lcdSegEnB,
	// alternate functions on port A
	input wire logic wakeupClkEn,
	input wire logic wakeupTimerClockOut,
	input wire logic nmiPinEn,
	input wire logic irqPinEn,
	output logic nonmaskableInterruptPin,
	output logic irqPinLevel,
	// pin edge requests, one per port
	output logic [NUM_PORTS-1:0] pinIrqReq
);
	ppc_top_st_t st;
	ppc_top_st_t next_st;
	ppc_bank_t syncPin;
	ppc_bank_t edgeHit;
	ppc_bank_t pullPolEff;
	logic [PORT_W-1:0] altOutA;
	logic [PORT_W-1:0] altOutValA;
	logic [PORT_W-1:0] altInA;
	logic [IDX_W-1:0] wordIdx;
	logic [IDX_W-1:0] rel;
	logic [PORT_SEL_W-1:0] selPort;
	logic [CFG_FIELD_W-1:0] selField;
	logic selHit;
	logic [PORT_W-1:0] rdByte;
	logic [PORT_W-1:0] wrByte;
	ppc_bank_t flagClr;
	logic wrEn;
	localparam logic [ADDR_W-1:0] ADDR_FLAG_R =
		{IDX_CFG_BASE + IDX_W'(PORT_R << CFG_FIELD_W) + IDX_W'(FLD_FLAG), 2'h0};

	if (NUM_PORTS != (1 << PORT_SEL_W) || PORT_W > 32) begin : g_chk
		$error("ppc_port_ab: port count or width not supported");
	end

	// ************************************************************
	// alternate functions on port A
	// ************************************************************
	assign altOutA = PORT_W'(wakeupClkEn) << PA_WKUP_BIT;
	assign altOutValA = PORT_W'(wakeupTimerClockOut) << PA_WKUP_BIT;
	assign altInA = (PORT_W'(nmiPinEn) << PA_NMI_BIT) |
		(PORT_W'(irqPinEn) << PA_IRQ_BIT);
	assign nonmaskableInterruptPin = syncPin[PORT_A][PA_NMI_BIT];
	assign irqPinLevel = syncPin[PORT_A][PA_IRQ_BIT];

	// ************************************************************
	// pin banks
	// ************************************************************
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		ppc_port_if #(.W(PORT_W)) pif ();

		// fixed polarity ports ignore the stored bits
		assign pullPolEff[p] = POL_FIXED_EN[p] ? {PORT_W{POL_FIXED_VAL[p]}} : st.pullPolarity[p];
		assign pif.dir = st.dir[p];
		assign pif.level = st.dataLatch[p];
		assign pif.reduced = st.reducedDrive[p];
		assign pif.pullEn = st.pullEnable[p];
		assign pif.pullPol = pullPolEff[p];
		assign pif.intEn = st.pinIntEnable[p];
		assign pif.lcdEn = (p == PORT_A) ? lcdSegEnA : ((p == PORT_B) ? lcdSegEnB : '0);
		assign pif.altOut = (p == PORT_A) ? altOutA : '0;
		assign pif.altOutVal = (p == PORT_A) ? altOutValA : '0;
		assign pif.altIn = (p == PORT_A) ? altInA : '0;
		assign syncPin[p] = pif.syncPin;
		assign edgeHit[p] = pif.edgeHit;
		assign pinIrqReq[p] = |st.flag[p];

		ppc_pin_bank #(.W(PORT_W)) u_bank (
			.clk(clk),
			.sys_rst(sys_rst),
			.port(pif.bank),
			.pinIn(pinIn[p]),
			.pinOut(pinOut[p]),
			.pinOen_n(pinOen_n[p]),
			.pinReduced(pinReduced[p]),
			.pinPullUp(pinPullUp[p]),
			.pinPullDown(pinPullDown[p]),
			.pinInBufEn(pinInBufEn[p])
		);
	end

	// ************************************************************
	// apb answer
	// ************************************************************
	assign pready = psel && penable;
	assign pslverr = psel && penable && st.slvErr;
	assign prdata = st.rdData;

	// ************************************************************
	// decode, registers and flags
	// ************************************************************
	always_comb begin
		next_st = st;
		wordIdx = paddr[ADDR_W-1:WORD_LSB];
		rel = wordIdx - IDX_CFG_BASE;
		selPort = '0;
		selField = FLD_DATA;
		selHit = 1'b0;
		rdByte = '0;
		flagClr = '0;
		wrByte = pwdata[PORT_W-1:0];
		wrEn = psel && penable && pwrite && pstrb[0];
		if (paddr[WORD_LSB-1:0] != '0) begin
			selHit = 1'b0;
		end else if (wordIdx < IDX_DATA_END) begin
			selHit = 1'b1;
			selPort = wordIdx[PORT_SEL_W-1:0];
		end else if (wordIdx >= IDX_CFG_BASE && wordIdx < IDX_CFG_END &&
			rel[CFG_FIELD_W-1:0] != FLD_DATA) begin
			selHit = 1'b1;
			selPort = rel[CFG_FIELD_W +: PORT_SEL_W];
			selField = rel[CFG_FIELD_W-1:0];
		end
		// read sources are all flops; pins are seen only through the synchroniser
		case (selField)
			FLD_DATA: rdByte = (st.dir[selPort] & st.dataLatch[selPort]) |
				(~st.dir[selPort] & syncPin[selPort]);
			FLD_DIR: rdByte = st.dir[selPort];
			FLD_RDR: rdByte = st.reducedDrive[selPort];
			FLD_PULL_EN: rdByte = st.pullEnable[selPort];
			FLD_PULL_POL: rdByte = pullPolEff[selPort];
			FLD_INT_EN: rdByte = st.pinIntEnable[selPort];
			FLD_FLAG: rdByte = st.flag[selPort];
			default: rdByte = syncPin[selPort];
		endcase
		// read data is captured in the setup cycle
		if (psel && !penable) begin
			next_st.rdData = {{(32 - PORT_W){1'b0}}, (selHit ? rdByte : REG_RST)};
			next_st.slvErr = !selHit;
		end
		if (wrEn && selHit) begin
			case (selField)
				FLD_DATA: next_st.dataLatch[selPort] = wrByte;
				FLD_DIR: next_st.dir[selPort] = wrByte;
				FLD_RDR: next_st.reducedDrive[selPort] = wrByte;
				FLD_PULL_EN: next_st.pullEnable[selPort] = wrByte;
				FLD_PULL_POL: next_st.pullPolarity[selPort] = wrByte;
				FLD_INT_EN: next_st.pinIntEnable[selPort] =
					wrByte & {PORT_W{PORT_HAS_INT[selPort]}};
				FLD_FLAG: flagClr[selPort] = wrByte;
				default: next_st.rdData = st.rdData;
			endcase
		end
		// a new edge in the clearing cycle keeps its flag
		for (int p = 0; p < NUM_PORTS; p++) begin
			next_st.flag[p] = (st.flag[p] & ~flagClr[p]) | edgeHit[p];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_dataRead;
		(psel && !penable && paddr == ADDR_DATA_A) |=> (prdata[PORT_W-1:0] ==
			(($past(st.dir[PORT_A]) & $past(st.dataLatch[PORT_A])) |
			(~$past(st.dir[PORT_A]) & $past(syncPin[PORT_A]))));
	endproperty
	a_dataRead: assert property (p_dataRead) else $error("port A read source wrong");

	property p_dataWrite;
		(psel && penable && pwrite && pstrb[0] && paddr == ADDR_DATA_B)
			|=> (st.dataLatch[PORT_B] == $past(pwdata[PORT_W-1:0]));
	endproperty
	a_dataWrite: assert property (p_dataWrite) else $error("port B latch not written");

	property p_noIntAB;
		(st.pinIntEnable[PORT_A] == '0) && (st.pinIntEnable[PORT_B] == '0);
	endproperty
	a_noIntAB: assert property (p_noIntAB) else $error("interrupt enable on port without it");

	property p_polFixed;
		(pullPolEff[PORT_A] == '1) && (pullPolEff[PORT_B] == '1) && (pullPolEff[PORT_AD] == '0);
	endproperty
	a_polFixed: assert property (p_polFixed) else $error("fixed polarity not held");

	property p_flagSet;
		(edgeHit[PORT_R] != '0) |=>
			((st.flag[PORT_R] & $past(edgeHit[PORT_R])) == $past(edgeHit[PORT_R]));
	endproperty
	a_flagSet: assert property (p_flagSet) else $error("edge flag lost");

	sequence s_setupBad;
		psel && !penable && paddr[WORD_LSB-1:0] != '0;
	endsequence
	property p_misaligned;
		s_setupBad ##1 (psel && penable) |-> pslverr && pready;
	endproperty
	a_misaligned: assert property (p_misaligned) else $error("misaligned access not refused");

	property p_segWins;
		((lcdSegEnA & ~pinOen_n[PORT_A]) | (lcdSegEnB & ~pinOen_n[PORT_B])) == '0;
	endproperty
	a_segWins: assert property (p_segWins) else $error("segment pin still driven");

	property p_wakeupOut;
		(wakeupClkEn && !lcdSegEnA[PA_WKUP_BIT]) |-> (!pinOen_n[PORT_A][PA_WKUP_BIT] &&
			pinOut[PORT_A][PA_WKUP_BIT] == wakeupTimerClockOut);
	endproperty
	a_wakeupOut: assert property (p_wakeupOut) else $error("wakeup clock not on its pin");

	property p_nmiIn;
		(nmiPinEn && !lcdSegEnA[PA_NMI_BIT]) |-> (pinOen_n[PORT_A][PA_NMI_BIT] &&
			pinInBufEn[PORT_A][PA_NMI_BIT]);
	endproperty
	a_nmiIn: assert property (p_nmiIn) else $error("nonmaskable input pin driven");

	property p_irqIn;
		(irqPinEn && !lcdSegEnA[PA_IRQ_BIT]) |-> (pinOen_n[PORT_A][PA_IRQ_BIT] &&
			pinInBufEn[PORT_A][PA_IRQ_BIT]);
	endproperty
	a_irqIn: assert property (p_irqIn) else $error("maskable input pin driven");

	property p_riseEdge;
		((st.pinIntEnable[PORT_R] & pullPolEff[PORT_R] & syncPin[PORT_R] &
			~$past(syncPin[PORT_R]) & ~edgeHit[PORT_R]) == '0);
	endproperty
	a_riseEdge: assert property (p_riseEdge) else $error("rising edge not reported");

	property p_pullAD;
		(pinPullUp[PORT_AD] == (~st.dir[PORT_AD] & st.pullEnable[PORT_AD])) &&
			(pinPullDown[PORT_AD] == '0);
	endproperty
	a_pullAD: assert property (p_pullAD) else $error("analog port pull device wrong");

	sequence s_setupDataA;
		psel && !penable && paddr == ADDR_DATA_A;
	endsequence
	property p_okAccess;
		s_setupDataA ##1 (psel && penable) |-> pready && !pslverr;
	endproperty
	a_okAccess: assert property (p_okAccess) else $error("data register access refused");

	sequence s_clearR;
		psel && penable && pwrite && pstrb[0] && paddr == ADDR_FLAG_R && edgeHit[PORT_R] == '0;
	endsequence
	property p_flagClear;
		s_clearR |=> ((st.flag[PORT_R] & $past(pwdata[PORT_W-1:0])) == '0);
	endproperty
	a_flagClear: assert property (p_flagClear) else $error("edge flag not cleared");
endmodule : ppc_port_ab
`default_nettype wire

/* File: tb/ppc_pad_model.sv */
// ppc_pad_model: pad levels that the port pin block sees from outside
`timescale 1ns/1ns
`default_nettype none
module ppc_pad_model
	import ppc_pkg::*;
(
	// clock
	input wire logic clk,
	// design pad side
	input wire ppc_bank_t pinOut,
	input wire ppc_bank_t pinOen_n,
	input wire ppc_bank_t pinPullUp,
	input wire ppc_bank_t pinPullDown,
	// outside drivers
	input wire ppc_bank_t extEn,
	input wire ppc_bank_t extVal,
	// pad level
	output var ppc_bank_t pinIn
);
	// ************************************************************
	// pad resolution
	// ************************************************************
	// undriven, unpulled pads wander so a stale level never passes
	ppc_bank_t floatVal = '0;
	always @(posedge clk) begin
		floatVal <= ~floatVal;
	end
	// design drive first, then outside drive, then pull device
	always_comb begin
		pinIn = (~pinOen_n & pinOut) | (pinOen_n & extEn & extVal);
		pinIn = pinIn | (pinOen_n & ~extEn & (pinPullUp | (~pinPullDown & floatVal)));
	end
endmodule : ppc_pad_model
`default_nettype wire

/* File: tb/ppc_port_ab_bench.sv */
// ppc_port_ab_bench: self-checking bench of the port pin configuration block
`timescale 1ns/1ns
`default_nettype none
module ppc_port_ab_bench
	import ppc_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [PORT_W-1:0] lcdSegEnA = '0, lcdSegEnB = '0;
	logic wakeupClkEn = 1'b0, wakeupTimerClockOut = 1'b0, nmiPinEn = 1'b0, irqPinEn = 1'b0;
	ppc_bank_t extEn = '0, extVal = '0;
	logic [31:0] prdata;
	logic pready, pslverr, nonmaskableInterruptPin, irqPinLevel;
	ppc_bank_t pinIn, pinOut, pinOen_n, pinReduced, pinPullUp, pinPullDown, pinInBufEn;
	logic [NUM_PORTS-1:0] pinIrqReq;
	logic [32:0] expQ[$];
	int err_count = 0, checks = 0, cycles = 0;
	integer seed = 45849;

	ppc_port_ab dut_u (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOen_n, .pinReduced, .pinPullUp,
		.pinPullDown, .pinInBufEn, .lcdSegEnA, .lcdSegEnB, .wakeupClkEn, .wakeupTimerClockOut,
		.nmiPinEn, .irqPinEn, .nonmaskableInterruptPin, .irqPinLevel, .pinIrqReq);
	ppc_pad_model pad_u (.clk, .pinOut, .pinOen_n, .pinPullUp, .pinPullDown, .extEn, .extVal,
		.pinIn);

	initial begin
		forever #2 clk = ~clk;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [ADDR_W-1:0] ca(input int p, input logic [CFG_FIELD_W-1:0] f);
		return {IDX_CFG_BASE + IDX_W'(p * 8) + IDX_W'(f), 2'h0};
	endfunction : ca

	function automatic logic [ADDR_W-1:0] da(input int p);
		return {IDX_W'(p), 2'h0};
	endfunction : da

	task automatic print_verdict();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic err = 1'b0);
		expQ.push_back({err, 24'h0, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	// read results checked in arrival order
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			cmp({pslverr, prdata}, expQ.pop_front());
		end
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		logic [7:0] d;
		logic [1:0] v;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			wr(ca(p, FLD_DIR), 8'hff);
			rd(da(p), REG_RST);
			d = 8'($random(seed));
			wr(da(p), d);
			rd(da(p), d);
			@(negedge clk);
			cmp(pinOut[p], d);
			cmp(pinOen_n[p], 8'h00);
			wr(ca(p, FLD_RDR), 8'hff);
			wr(ca(p, FLD_PULL_EN), 8'hff);
			extEn[p] <= 8'hff;
			extVal[p] <= 8'($random(seed));
			@(negedge clk);
			cmp(pinReduced[p], 8'hff);
			cmp(pinPullUp[p] | pinPullDown[p], 8'h00);
			wr(ca(p, FLD_DIR), 8'h00);
			repeat (2) @(posedge clk);
			rd(da(p), extVal[p]);
			@(negedge clk);
			cmp(pinPullDown[p], 8'hff);
			wr(ca(p, FLD_PULL_POL), 8'h00);
			rd(ca(p, FLD_PULL_POL), 8'hff);
			wr(ca(p, FLD_INT_EN), 8'hff);
			rd(ca(p, FLD_INT_EN), 8'h00);
			d = 8'($random(seed));
			wr(da(p), d);
			extEn[p] <= 8'h00;
			wr(ca(p, FLD_DIR), 8'hff);
			rd(da(p), d);
		end
		wr(ca(PORT_AD, FLD_PULL_POL), 8'hff);
		wr(ca(PORT_AD, FLD_PULL_EN), 8'hff);
		rd(ca(PORT_AD, FLD_PULL_POL), 8'h00);
		@(negedge clk);
		cmp(pinPullUp[PORT_AD], 8'hff);
		// edge flags on interrupt capable port R, both polarities
		wr(ca(PORT_R, FLD_INT_EN), 8'hff);
		extEn[PORT_R] <= 8'hff;
		for (int pol = 0; pol < 2; pol++) begin
			extVal[PORT_R] <= {8{~pol[0]}};
			repeat (4) @(posedge clk);
			wr(ca(PORT_R, FLD_PULL_POL), {8{pol[0]}});
			wr(ca(PORT_R, FLD_FLAG), 8'hff);
			rd(ca(PORT_R, FLD_FLAG), 8'h00);
			extVal[PORT_R] <= {8{pol[0]}};
			repeat (5) @(posedge clk);
			rd(ca(PORT_R, FLD_FLAG), 8'hff);
			@(negedge clk);
			cmp(pinIrqReq[PORT_R], 1'b1);
			wr(ca(PORT_R, FLD_FLAG), 8'hff);
			extVal[PORT_R] <= {8{~pol[0]}};
			repeat (5) @(posedge clk);
			rd(ca(PORT_R, FLD_FLAG), 8'h00);
		end
		// alternate functions on port A
		wr(ca(PORT_A, FLD_DIR), 8'h00);
		wakeupClkEn <= 1'b1;
		wakeupTimerClockOut <= 1'($random(seed));
		@(negedge clk);
		cmp(pinOen_n[PORT_A][PA_WKUP_BIT], 1'b0);
		cmp(pinOut[PORT_A][PA_WKUP_BIT], wakeupTimerClockOut);
		@(posedge clk);
		lcdSegEnA <= 8'h08;
		@(negedge clk);
		cmp({pinOen_n[PORT_A][PA_WKUP_BIT], pinInBufEn[PORT_A][PA_WKUP_BIT]}, 2'b10);
		wr(ca(PORT_A, FLD_DIR), 8'hff);
		nmiPinEn <= 1'b1;
		irqPinEn <= 1'b1;
		lcdSegEnA <= 8'h00;
		v = 2'($random(seed));
		extEn[PORT_A] <= 8'h03;
		extVal[PORT_A] <= {6'h0, v};
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp(pinOen_n[PORT_A][PA_NMI_BIT:PA_IRQ_BIT], 2'b11);
		cmp({nonmaskableInterruptPin, irqPinLevel}, v);
		@(posedge clk);
		lcdSegEnA <= 8'h03;
		extVal[PORT_A] <= 8'h03;
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp({pinInBufEn[PORT_A][1:0], nonmaskableInterruptPin, irqPinLevel}, 4'h0);
		@(posedge clk);
		lcdSegEnB <= 8'($random(seed));
		@(negedge clk);
		cmp({pinOen_n[PORT_B], pinInBufEn[PORT_B]}, {lcdSegEnB, ~lcdSegEnB});
		// misaligned, unused field and unmapped index are refused
		rd(12'h001, 8'h00, 1'b1);
		rd(ca(PORT_A, FLD_DATA), 8'h00, 1'b1);
		rd(12'hffc, 8'h00, 1'b1);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule : ppc_port_ab_bench
`default_nettype wire
